// ### logic/fpsi_pkg.sv
// Constants for the flash programming register front end
// Notes on behaviour
// R1 - Status register is read-only; bits 7..5 show the active security lock option.
// R2 - Status bit 3 is high while busy, low when next burst program may start; the code drops it in the burst gap but accepts commands only in FPSI_IDLE.
// R3 - Status bit 2 is high until the last command, burst included, fully completes.
// R4 - Config bit 7 makes the 4 KByte upper block visible at F000-FFFF.
// R5 - Config bit 6 enables run-time flash commands; when low they are ignored.
// R6 - Every reset loads config bits 1..0 from the nonvolatile remap bits; the code loads their inverse on the first clock after reset.
// R7 - Remap field: 00 none, 01 1K, 10 2K, 11 4K redirected to F000h.
// R8 - Software remap writes act at run time and never touch nonvolatile bits.
// R9 - Command bit 7 turns interrupt line one into a completion signal, masking the pin.
// R10 - Codes 01h chip erase, 06h burst program, 0Bh sector erase start operations.
// R11 - Codes 0Ch byte verify, 0Dh block erase, 0Eh byte program.
// R12 - Any other command code starts nothing.
// R13 - Byte verify answers in one cycle and never raises the completion interrupt.
// R14 - Software gives address low byte then high byte in two registers.
// R15 - Data register holds program byte, and the read byte after verify.
// R16 - Software polls busy or waits for completion before new commands.
package fpsi_pkg;
    localparam logic [7:0] FPSI_ADDR_CONFIG = 8'hB1;
    localparam logic [7:0] FPSI_ADDR_COMMAND = 8'hB2;
    localparam logic [7:0] FPSI_ADDR_ADDR_LOW = 8'hB3;
    localparam logic [7:0] FPSI_ADDR_ADDR_HIGH = 8'hB4;
    localparam logic [7:0] FPSI_ADDR_DATA = 8'hB5;
    localparam logic [7:0] FPSI_ADDR_STATUS = 8'hB6;
    localparam int FPSI_CFG_VISIBLE_BIT = 7;
    localparam int FPSI_CFG_CMD_ENABLE_BIT = 6;
    localparam int FPSI_CMD_IRQ_ENABLE_BIT = 7;
    localparam int FPSI_ST_BUSY_BIT = 3;
    localparam int FPSI_ST_FLASH_BUSY_BIT = 2;
    localparam int FPSI_ST_LOCK_LSB = 5;
    localparam logic [7:0] FPSI_RESET_COMMAND = 8'h00;
    localparam logic [7:0] FPSI_RESET_BYTE = 8'h00;
    localparam logic [6:0] FPSI_OP_CHIP_ERASE = 7'h01;
    localparam logic [6:0] FPSI_OP_BURST_PROGRAM = 7'h06;
    localparam logic [6:0] FPSI_OP_SECTOR_ERASE = 7'h0B;
    localparam logic [6:0] FPSI_OP_BYTE_VERIFY = 7'h0C;
    localparam logic [6:0] FPSI_OP_BLOCK_ERASE = 7'h0D;
    localparam logic [6:0] FPSI_OP_BYTE_PROGRAM = 7'h0E;
    localparam logic [15:0] FPSI_UPPER_BASE = 16'hF000;
    localparam logic [15:0] FPSI_REMAP_1K_TOP = 16'h03FF;
    localparam logic [15:0] FPSI_REMAP_2K_TOP = 16'h07FF;
    localparam logic [15:0] FPSI_REMAP_4K_TOP = 16'h0FFF;
    typedef enum logic [1:0] {FPSI_IDLE, FPSI_RUN, FPSI_BURST_GAP} fpsi_state_e;
    function automatic logic fpsi_cmd_valid(input logic [6:0] code);
        return code == FPSI_OP_CHIP_ERASE || code == FPSI_OP_BURST_PROGRAM
            || code == FPSI_OP_SECTOR_ERASE || code == FPSI_OP_BYTE_VERIFY
            || code == FPSI_OP_BLOCK_ERASE || code == FPSI_OP_BYTE_PROGRAM;
    endfunction
endpackage

// ### logic/fpsi_remap.sv
// Program fetch address remapping and upper block visibility
`timescale 1ns/100ps
`default_nettype none
module fpsi_remap
(
    // Control
    input wire logic [1:0] remap_size,
    input wire logic upper_block_visible,
    // Fetch
    input wire logic [15:0] fetch_addr,
    output logic [15:0] mapped_addr,
    output logic upper_block_select
);
    import fpsi_pkg::*;
    logic [15:0] top;
    // R7 remap window
    always_comb
    begin
        case (remap_size)
            2'b01: top = FPSI_REMAP_1K_TOP;
            2'b10: top = FPSI_REMAP_2K_TOP;
            2'b11: top = FPSI_REMAP_4K_TOP;
            default: top = 16'h0000;
        endcase
        if (remap_size != 2'b00 && fetch_addr <= top)
            mapped_addr = FPSI_UPPER_BASE | fetch_addr;
        else
            mapped_addr = fetch_addr;
    end
    // R4 upper block visible
    assign upper_block_select = upper_block_visible && (mapped_addr >= FPSI_UPPER_BASE);
endmodule
`default_nettype wire

// ### logic/fpsi_top.sv
// Flash programming register front end
`timescale 1ns/100ps
`default_nettype none
module fpsi_top
#(
    parameter int OP_CYCLES = 64,
    parameter int BURST_GAP_CYCLES = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Nonvolatile and lock inputs
    input wire logic [1:0] nonvolatile_remap_bits,
    input wire logic [2:0] security_lock_bits,
    // Flash array side
    input wire logic [7:0] flash_read_byte,
    output logic flash_start,
    output logic [6:0] flash_op,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wbyte,
    // Interrupt line one
    input wire logic external_interrupt_line_one,
    output logic external_interrupt_line_one_out,
    // Program fetch
    input wire logic [15:0] fetch_addr,
    output logic [15:0] mapped_addr,
    output logic upper_block_select
);
    import fpsi_pkg::*;
    logic [7:0] command;
    logic [7:0] addr_low;
    logic [7:0] addr_high;
    logic [7:0] data;
    logic upper_block_visible;
    logic runtime_command_enable;
    logic [1:0] remap_size;
    logic remap_loaded;
    logic [2:0] pin_sync;
    logic pin_level;
    fpsi_state_e state;
    logic [15:0] count;
    logic burst_op;
    logic done_flag;
    logic completion_irq_enable;
    logic [6:0] command_code;
    logic cmd_write;
    logic go;
    logic verify_go;
    logic busy;
    logic flash_busy;
    assign completion_irq_enable = command[FPSI_CMD_IRQ_ENABLE_BIT];
    assign command_code = command[6:0];
    assign cmd_write = reg_write && reg_addr == FPSI_ADDR_COMMAND;
    // R5 R10 R11 R12 command acceptance
    assign go = cmd_write && runtime_command_enable && fpsi_cmd_valid(reg_wdata[6:0])
        && state == FPSI_IDLE;
    // R13 verify is immediate
    assign verify_go = go && reg_wdata[6:0] == FPSI_OP_BYTE_VERIFY;
    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            command <= FPSI_RESET_COMMAND;
            addr_low <= FPSI_RESET_BYTE;
            addr_high <= FPSI_RESET_BYTE;
        end
        else if (reg_write)
        begin
            if (reg_addr == FPSI_ADDR_COMMAND)
                command <= reg_wdata;
            else if (reg_addr == FPSI_ADDR_ADDR_LOW)
                addr_low <= reg_wdata;
            else if (reg_addr == FPSI_ADDR_ADDR_HIGH)
                addr_high <= reg_wdata;
        end
    end
    // R15 data mailbox
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            data <= FPSI_RESET_BYTE;
        else if (verify_go)
            data <= flash_read_byte;
        else if (reg_write && reg_addr == FPSI_ADDR_DATA)
            data <= reg_wdata;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            upper_block_visible <= 1'b0;
            runtime_command_enable <= 1'b0;
        end
        else if (reg_write && reg_addr == FPSI_ADDR_CONFIG)
        begin
            upper_block_visible <= reg_wdata[FPSI_CFG_VISIBLE_BIT];
            runtime_command_enable <= reg_wdata[FPSI_CFG_CMD_ENABLE_BIT];
        end
    end
    // R6 R8 remap load after reset, software override
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            remap_size <= 2'b00;
            remap_loaded <= 1'b0;
        end
        else if (!remap_loaded)
        begin
            remap_size <= ~nonvolatile_remap_bits;
            remap_loaded <= 1'b1;
        end
        else if (reg_write && reg_addr == FPSI_ADDR_CONFIG)
            remap_size <= reg_wdata[1:0];
    end
    // ----------------------------------------
    // Operation sequencer
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= FPSI_IDLE;
            count <= 16'h0000;
            burst_op <= 1'b0;
        end
        else
        begin
            case (state)
                FPSI_IDLE:
                    if (go && !verify_go)
                    begin
                        state <= FPSI_RUN;
                        count <= 16'(OP_CYCLES - 1);
                        burst_op <= reg_wdata[6:0] == FPSI_OP_BURST_PROGRAM;
                    end
                FPSI_RUN:
                    if (count != 16'h0000)
                        count <= count - 16'h0001;
                    else if (burst_op)
                    begin
                        state <= FPSI_BURST_GAP;
                        count <= 16'(BURST_GAP_CYCLES - 1);
                    end
                    else
                        state <= FPSI_IDLE;
                FPSI_BURST_GAP:
                    if (count != 16'h0000)
                        count <= count - 16'h0001;
                    else
                        state <= FPSI_IDLE;
                default:
                    state <= FPSI_IDLE;
            endcase
        end
    end
    // R2 R3 busy flags
    assign busy = state == FPSI_RUN;
    assign flash_busy = state != FPSI_IDLE;
    // R9 completion flag, set wins over clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            done_flag <= 1'b0;
        else if (state != FPSI_IDLE && count == 16'h0000 && !(state == FPSI_RUN && burst_op))
            done_flag <= 1'b1;
        else if (cmd_write)
            done_flag <= 1'b0;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_sync <= 3'b111;
        else
            pin_sync <= {pin_sync[1:0], external_interrupt_line_one};
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_level <= 1'b1;
        else if (pin_sync[2] == pin_sync[1])
            pin_level <= pin_sync[2];
    end
    // R9 line one reassignment, active low
    assign external_interrupt_line_one_out = completion_irq_enable ? ~done_flag : pin_level;
    // R14 target address
    assign flash_addr = {addr_high, addr_low};
    assign flash_wbyte = data;
    assign flash_op = command_code;
    assign flash_start = go;
    // R1 read mux
    always_comb
    begin
        if (reg_addr == FPSI_ADDR_CONFIG)
            reg_rdata = {upper_block_visible, runtime_command_enable, 4'h0, remap_size};
        else if (reg_addr == FPSI_ADDR_COMMAND)
            reg_rdata = command;
        else if (reg_addr == FPSI_ADDR_ADDR_LOW)
            reg_rdata = addr_low;
        else if (reg_addr == FPSI_ADDR_ADDR_HIGH)
            reg_rdata = addr_high;
        else if (reg_addr == FPSI_ADDR_DATA)
            reg_rdata = data;
        else if (reg_addr == FPSI_ADDR_STATUS)
            reg_rdata = {security_lock_bits, 1'b0, busy, flash_busy, 2'b00};
        else
            reg_rdata = 8'h00;
    end
    fpsi_remap u_remap
    (
        .remap_size(remap_size),
        .upper_block_visible(upper_block_visible),
        .fetch_addr(fetch_addr),
        .mapped_addr(mapped_addr),
        .upper_block_select(upper_block_select)
    );
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_verify_data;
        @(posedge clk) disable iff (!rst_n) verify_go |=> data == $past(flash_read_byte);
    endproperty
    a_verify_data: assert property (p_verify_data) else $error("verify byte not stored"); // R13
    property p_verify_idle;
        @(posedge clk) disable iff (!rst_n) verify_go |=> state == FPSI_IDLE && !done_flag;
    endproperty
    a_verify_idle: assert property (p_verify_idle) else $error("verify raised busy or done"); // R13
    property p_gate;
        @(posedge clk) disable iff (!rst_n) cmd_write && !runtime_command_enable |-> !go;
    endproperty
    a_gate: assert property (p_gate) else $error("disabled command accepted"); // R5
    property p_reserved;
        @(posedge clk) disable iff (!rst_n) cmd_write && !fpsi_cmd_valid(reg_wdata[6:0]) |-> !flash_start;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code started"); // R12
    property p_busy_order;
        @(posedge clk) disable iff (!rst_n) busy |-> flash_busy;
    endproperty
    a_busy_order: assert property (p_busy_order) else $error("busy without flash busy"); // R3
    property p_start_busy;
        @(posedge clk) disable iff (!rst_n) go && !verify_go |=> busy && flash_busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy not raised"); // R2
    property p_external_interrupt_line_one;
        @(posedge clk) disable iff (!rst_n) completion_irq_enable |-> external_interrupt_line_one_out == !done_flag;
    endproperty
    a_external_interrupt_line_one: assert property (p_external_interrupt_line_one) else $error("line one not reassigned"); // R9
    property p_remap_hold;
        @(posedge clk) disable iff (!rst_n)
            remap_loaded && !(reg_write && reg_addr == FPSI_ADDR_CONFIG) |=> $stable(remap_size);
    endproperty
    a_remap_hold: assert property (p_remap_hold) else $error("remap changed alone"); // R8
    property p_status_lock;
        @(posedge clk) disable iff (!rst_n)
            reg_addr == FPSI_ADDR_STATUS |-> reg_rdata[7:5] == security_lock_bits;
    endproperty
    a_status_lock: assert property (p_status_lock) else $error("lock bits wrong"); // R1
    c_burst: cover property (@(posedge clk) disable iff (!rst_n) state == FPSI_BURST_GAP);
    c_verify: cover property (@(posedge clk) disable iff (!rst_n) verify_go);
    c_done_irq: cover property (@(posedge clk) disable iff (!rst_n) completion_irq_enable && done_flag);
endmodule
`default_nettype wire

// ### tb/fpsi_flash_model.sv
// Behavioural flash array standing behind the register front end
`timescale 1ns/100ps
`default_nettype none
module fpsi_flash_model
    import fpsi_pkg::*;
(
    // Clock
    input wire logic clk,
    // Array port
    input wire logic flash_start,
    input wire logic [6:0] flash_op,
    input wire logic [15:0] flash_addr,
    input wire logic [7:0] flash_wbyte,
    output logic [7:0] flash_read_byte
);
    logic [7:0] mem [16];
    logic start_q;
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    assign flash_read_byte = mem[flash_addr[3:0]];
    // operation decode, a cycle after start once the command field holds the new code
    always @(posedge clk)
    begin
        start_q <= flash_start;
        if (start_q)
        begin
            if (flash_op inside {FPSI_OP_CHIP_ERASE, FPSI_OP_SECTOR_ERASE, FPSI_OP_BLOCK_ERASE})
                foreach (mem[i]) mem[i] <= 8'hFF;
            else if (flash_op inside {FPSI_OP_BURST_PROGRAM, FPSI_OP_BYTE_PROGRAM})
                mem[flash_addr[3:0]] <= flash_wbyte;
        end
    end
endmodule
`default_nettype wire

// ### tb/flash_prog_sfr_interface_tb_top.sv
// Self-checking bench for the flash programming register front end
`timescale 1ns/100ps
`default_nettype none
module flash_prog_sfr_interface_tb_top;
    import fpsi_pkg::*;
    logic clk, rst_n, reg_write, flash_start, int_pin, external_interrupt_line_one_out, upper_sel, started;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_byte, flash_wbyte, seen, dval, mirror;
    logic [1:0] nv_bits;
    logic [2:0] lock_bits;
    logic [6:0] flash_op, code;
    logic [15:0] flash_addr, fetch_addr, mapped_addr, addr, top, em;
    logic [6:0] codes [7] = '{7'h01, 7'h0E, 7'h0C, 7'h06, 7'h0B, 7'h0D, 7'h0C};
    int err_count, check_count;
    fpsi_top #(.OP_CYCLES(4), .BURST_GAP_CYCLES(2)) dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .nonvolatile_remap_bits(nv_bits),
        .security_lock_bits(lock_bits), .flash_read_byte(rd_byte), .flash_start(flash_start), .flash_op(flash_op),
        .flash_addr(flash_addr), .flash_wbyte(flash_wbyte), .external_interrupt_line_one(int_pin),
        .external_interrupt_line_one_out(external_interrupt_line_one_out), .fetch_addr(fetch_addr), .mapped_addr(mapped_addr), .upper_block_select(upper_sel));
    fpsi_flash_model flash (.clk(clk), .flash_start(flash_start), .flash_op(flash_op), .flash_addr(flash_addr),
        .flash_wbyte(flash_wbyte), .flash_read_byte(rd_byte));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(negedge clk);
        started = flash_start;
        @(posedge clk);
        reg_write <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        @(negedge clk);
        seen = reg_rdata;
    endtask
    // poll one status bit until low, bounded
    task automatic wait_low(input int b);
        int n;
        n = 0;
        seen = 8'hFF;
        while (seen[b] !== 1'b0)
        begin
            if (n == 40)
            begin
                err_count++;
                tally_and_finish();
            end
            rd(FPSI_ADDR_STATUS);
            n++;
        end
    endtask
    function automatic logic [15:0] exp_map(input logic [1:0] sz, input logic [15:0] a);
        logic [15:0] t;
        t = (sz == 2'b01) ? 16'h03FF : (sz == 2'b10) ? 16'h07FF : 16'h0FFF;
        return (sz != 2'b00 && a <= t) ? (16'hF000 | a) : a;
    endfunction
    initial
    begin
        rst_n = 1'b0;
        reg_write = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        nv_bits = 2'b01;
        lock_bits = 3'b101;
        int_pin = 1'b1;
        fetch_addr = 16'h0000;
        err_count = 0;
        check_count = 0;
        void'($urandom(68476));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(FPSI_ADDR_CONFIG);
        chk(seen, {6'b00_0000, ~nv_bits});
        for (int a = 8'hB2; a <= 8'hB5; a++)
        begin
            rd(8'(a));
            chk(seen, 8'h00);
        end
        rd(8'hB7);
        chk(seen, 8'h00);
        chk(external_interrupt_line_one_out, 1'b1);
        wr(FPSI_ADDR_STATUS, 8'hFF);
        rd(FPSI_ADDR_STATUS);
        chk(seen, {lock_bits, 5'b0_0000});
        for (int m = 0; m < 8; m++)
        begin
            wr(FPSI_ADDR_CONFIG, {m[2], 5'b0_0000, m[1:0]});
            top = (m[1:0] == 2'b10) ? 16'h07FF : (m[1:0] == 2'b11) ? 16'h0FFF : 16'h03FF;
            for (int k = 0; k < 6; k++)
            begin
                @(posedge clk);
                fetch_addr <= (k == 0) ? top : (k == 1) ? top + 16'h0001 : 16'($urandom);
                @(negedge clk);
                em = exp_map(m[1:0], fetch_addr);
                chk(mapped_addr, em);
                chk(upper_sel, m[2] && em >= 16'hF000);
            end
        end
        wr(FPSI_ADDR_CONFIG, 8'h00);
        wr(FPSI_ADDR_COMMAND, {1'b0, FPSI_OP_BYTE_PROGRAM});
        chk(started, 1'b0);
        rd(FPSI_ADDR_STATUS);
        chk(seen, {lock_bits, 5'b0_0000});
        wr(FPSI_ADDR_CONFIG, 8'h40);
        for (int k = 0; k < 8; k++)
        begin
            code = 7'($urandom);
            if (code inside {7'h01, 7'h06, 7'h0B, 7'h0C, 7'h0D, 7'h0E})
                code = 7'h7F;
            wr(FPSI_ADDR_COMMAND, {1'b0, code});
            chk(started, 1'b0);
        end
        rd(FPSI_ADDR_STATUS);
        chk(seen, {lock_bits, 5'b0_0000});
        @(posedge clk);
        int_pin <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk(external_interrupt_line_one_out, 1'b0);
        addr = 16'($urandom);
        wr(FPSI_ADDR_ADDR_LOW, addr[7:0]);
        wr(FPSI_ADDR_ADDR_HIGH, addr[15:8]);
        mirror = 8'hFF;
        foreach (codes[i])
        begin
            dval = 8'($urandom);
            wr(FPSI_ADDR_DATA, dval);
            wr(FPSI_ADDR_COMMAND, {1'b1, codes[i]});
            chk(started, 1'b1);
            chk(flash_op, codes[i]);
            chk(flash_addr, addr);
            chk(external_interrupt_line_one_out, 1'b1);
            if (codes[i] == FPSI_OP_BYTE_VERIFY)
            begin
                rd(FPSI_ADDR_DATA);
                chk(seen, mirror);
                rd(FPSI_ADDR_STATUS);
                chk(seen, {lock_bits, 5'b0_0000});
                chk(external_interrupt_line_one_out, 1'b1);
            end
            else
            begin
                chk(flash_wbyte, dval);
                rd(FPSI_ADDR_STATUS);
                chk(seen[3:2], 2'b11);
                wr(FPSI_ADDR_COMMAND, {1'b1, codes[i]});
                chk(started, 1'b0);
                wait_low(FPSI_ST_BUSY_BIT);
                if (codes[i] == FPSI_OP_BURST_PROGRAM)
                    chk(seen[2], 1'b1);
                wait_low(FPSI_ST_FLASH_BUSY_BIT);
                chk(external_interrupt_line_one_out, 1'b0);
                mirror = (codes[i] inside {7'h06, 7'h0E}) ? dval : 8'hFF;
            end
        end
        @(posedge clk);
        nv_bits <= 2'($urandom);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(FPSI_ADDR_CONFIG);
        chk(seen, {6'b00_0000, ~nv_bits});
        tally_and_finish();
    end
endmodule
`default_nettype wire
